// File: hdl/apoc_defs.vh
// Constants for the converter digital output control block.
// Assumes inclusion by the design file and by the bench top.
`ifndef APOC_DEFS_VH
`define APOC_DEFS_VH

// APB register byte offsets
`define APOC_ADDR_CTRL     12'h000
`define APOC_ADDR_STATUS   12'h004
`define APOC_ADDR_IRQ_STAT 12'h008
`define APOC_ADDR_IRQ_MASK 12'h00C
`define APOC_ADDR_SAMPLE   12'h010
`define APOC_ADDR_COUNT    12'h014

// Control register fields
`define APOC_CTRL_OE_N     0
`define APOC_CTRL_PD       1
`define APOC_CTRL_RESET    32'h0000_0001

// Strap level encodings (0, 1/3, 2/3, full supply)
`define APOC_STRAP_GND     2'h0
`define APOC_STRAP_THIRD   2'h1
`define APOC_STRAP_TWO3RD  2'h2
`define APOC_STRAP_VDD     2'h3

// Interrupt status bits
`define APOC_IRQ_OVF       0
`define APOC_IRQ_READY     1
`define APOC_IRQ_LOCK      2
`define APOC_IRQ_W         3

// Recovery and relock counts, in encode clock cycles
`define APOC_NAP_CYCLES    16'h0064
`define APOC_LOCK_CYCLES   16'h0064
// Sleep recovery time in microseconds
`define APOC_SLEEP_US      32'h0000_0BB8
`define APOC_CLK_MHZ       32'h0000_000A
// Encode clock considered stopped after this many pclk cycles
`define APOC_STOP_CYCLES   16'h0100

// Saturation codes
`define APOC_FULL_OB       12'hFFF
`define APOC_ZERO_OB       12'h000
`define APOC_SIGN_BIT      11

`endif

// File: hdl/apoc_output_ctrl.v
// Digital output side of a 12-bit sampling converter: coding, overflow,
// sample clock out, tri-state control, sleep and nap with recovery.
// Assumes the encode clock arrives asynchronously to pclk, and that the
// converter core supplies a raw offset-binary word with range flags.
//
// Design decisions made here: register access over APB and the address map.
`default_nettype none
`include "apoc_defs.vh"

module apoc_output_ctrl #(
    parameter WIDTH = 12,
    parameter SLEEP_CYCLES = 30000
) (
    input wire pclk,
    input wire presetn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire sampling_edge_pos,
    input wire [1:0] mode_strap,
    input wire [WIDTH-1:0] raw_word,
    input wire raw_over,
    input wire raw_under,
    output reg [WIDTH-1:0] sample_word,
    output wire [WIDTH-1:0] sample_word_oe,
    output reg overflow_flag,
    output wire overflow_flag_oe,
    output reg output_sample_clock,
    output wire output_sample_clock_oe,
    output wire twos_comp,
    output wire stabilizer_on,
    output wire sleep_mode,
    output wire nap_mode,
    output wire data_valid,
    output wire irq
);

// ----------------------------------------
// Power states
// ----------------------------------------
localparam ST_RUN = 4'b0001;
localparam ST_SLEEP = 4'b0010;
localparam ST_NAP = 4'b0100;
localparam ST_RECOVER = 4'b1000;

// ----------------------------------------
// Encode clock synchroniser
// ----------------------------------------
reg enc_s1_q, enc_s2_q, enc_s3_q;
reg enc_lvl_q;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        enc_s1_q <= 1'b0;
        enc_s2_q <= 1'b0;
        enc_s3_q <= 1'b0;
        enc_lvl_q <= 1'b0;
    end else begin
        enc_s1_q <= sampling_edge_pos;
        enc_s2_q <= enc_s1_q;
        enc_s3_q <= enc_s2_q;
        if (enc_s2_q == enc_s3_q) begin
            enc_lvl_q <= enc_s3_q;
        end
    end
end
wire enc_rise = (enc_s2_q == enc_s3_q) && enc_s3_q && !enc_lvl_q;
wire enc_fall = (enc_s2_q == enc_s3_q) && !enc_s3_q && enc_lvl_q;

// ----------------------------------------
// Strap decode
// ----------------------------------------
// Strap caught after reset release, not under the async reset
reg strap_done_q;
reg twos_q, dcs_q;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        strap_done_q <= 1'b0;
        twos_q <= 1'b0;
        dcs_q <= 1'b0;
    end else if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        twos_q <= (mode_strap == `APOC_STRAP_TWO3RD) || (mode_strap == `APOC_STRAP_VDD);
        dcs_q <= (mode_strap == `APOC_STRAP_THIRD) || (mode_strap == `APOC_STRAP_TWO3RD);
    end
end
assign twos_comp = twos_q;
assign stabilizer_on = dcs_q;

// ----------------------------------------
// APB registers
// ----------------------------------------
reg [31:0] ctrl_q;
reg [`APOC_IRQ_W-1:0] irq_stat_q, irq_mask_q;
reg [15:0] sample_cnt_q;
wire wr = psel && penable && pwrite;
wire rd_en = psel && !pwrite;
wire addr_ok = (paddr == `APOC_ADDR_CTRL) || (paddr == `APOC_ADDR_STATUS) ||
               (paddr == `APOC_ADDR_IRQ_STAT) || (paddr == `APOC_ADDR_IRQ_MASK) ||
               (paddr == `APOC_ADDR_SAMPLE) || (paddr == `APOC_ADDR_COUNT);
assign pready = 1'b1;
assign pslverr = psel && penable && !addr_ok;
wire oe_n = ctrl_q[`APOC_CTRL_OE_N];
wire pd = ctrl_q[`APOC_CTRL_PD];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_q <= `APOC_CTRL_RESET;
        irq_mask_q <= {`APOC_IRQ_W{1'b0}};
    end else if (wr && paddr == `APOC_ADDR_CTRL) begin
        ctrl_q <= pwdata & 32'h0000_0003;
    end else if (wr && paddr == `APOC_ADDR_IRQ_MASK) begin
        irq_mask_q <= pwdata[`APOC_IRQ_W-1:0];
    end
end

// ----------------------------------------
// Power state machine
// ----------------------------------------
reg [3:0] pst_q, pst_d;
reg [31:0] rec_cnt_q, rec_cnt_d;
reg ready_evt;
reg sleep_q;
always @* begin
    pst_d = pst_q;
    rec_cnt_d = rec_cnt_q;
    ready_evt = 1'b0;
    case (pst_q)
        ST_RUN: begin
            if (pd) begin
                pst_d = oe_n ? ST_SLEEP : ST_NAP;
            end
        end
        ST_SLEEP, ST_NAP: begin
            if (!pd) begin
                pst_d = ST_RECOVER;
                rec_cnt_d = (pst_q == ST_SLEEP) ? SLEEP_CYCLES : {16'h0000, `APOC_NAP_CYCLES};
            end else begin
                // Enable level picks sleep or nap while powered down
                pst_d = oe_n ? ST_SLEEP : ST_NAP;
            end
        end
        ST_RECOVER: begin
            if (pd) begin
                pst_d = oe_n ? ST_SLEEP : ST_NAP;
            end else if (rec_cnt_q == 32'h0000_0000) begin
                pst_d = ST_RUN;
                ready_evt = 1'b1;
            end else if (sleep_q || enc_rise) begin
                // Sleep counts pclk time, nap counts encode cycles
                rec_cnt_d = rec_cnt_q - 32'h0000_0001;
            end
        end
        default: pst_d = ST_RUN;
    endcase
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pst_q <= ST_RUN;
        rec_cnt_q <= 32'h0000_0000;
        sleep_q <= 1'b0;
    end else begin
        pst_q <= pst_d;
        rec_cnt_q <= rec_cnt_d;
        if (pst_q == ST_SLEEP) begin
            sleep_q <= 1'b1;
        end else if (pst_q == ST_NAP) begin
            sleep_q <= 1'b0;
        end
    end
end
assign sleep_mode = (pst_q == ST_SLEEP);
assign nap_mode = (pst_q == ST_NAP);
wire running = (pst_q == ST_RUN);

// ----------------------------------------
// Stabilizer lock
// ----------------------------------------
reg [15:0] stop_cnt_q, lock_cnt_q;
reg locked_q;
reg lock_evt_q;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stop_cnt_q <= 16'h0000;
        lock_cnt_q <= 16'h0000;
        locked_q <= 1'b0;
        lock_evt_q <= 1'b0;
    end else begin
        lock_evt_q <= 1'b0;
        if (enc_rise) begin
            stop_cnt_q <= 16'h0000;
        end else if (stop_cnt_q != `APOC_STOP_CYCLES) begin
            stop_cnt_q <= stop_cnt_q + 16'h0001;
        end
        // relock after stop
        // Wait for the strap decode, else a stabilizer part skips its first lock
        if (!dcs_q) begin
            locked_q <= strap_done_q;
        end else if (stop_cnt_q == `APOC_STOP_CYCLES) begin
            locked_q <= 1'b0;
            lock_cnt_q <= 16'h0000;
        end else if (!locked_q && enc_rise) begin
            if (lock_cnt_q == `APOC_LOCK_CYCLES - 16'h0001) begin
                locked_q <= 1'b1;
                lock_evt_q <= 1'b1;
            end else begin
                lock_cnt_q <= lock_cnt_q + 16'h0001;
            end
        end
    end
end

// ----------------------------------------
// Output path
// ----------------------------------------
// midpoint fall timer
reg [15:0] half_q, per_cnt_q, mid_cnt_q;
reg mid_fall_q;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        half_q <= 16'h0001;
        per_cnt_q <= 16'h0000;
        mid_cnt_q <= 16'h0000;
        mid_fall_q <= 1'b0;
    end else begin
        mid_fall_q <= 1'b0;
        if (enc_rise) begin
            half_q <= {1'b0, per_cnt_q[15:1]};
            per_cnt_q <= 16'h0000;
            mid_cnt_q <= 16'h0000;
        end else begin
            per_cnt_q <= per_cnt_q + 16'h0001;
            mid_cnt_q <= mid_cnt_q + 16'h0001;
            if (mid_cnt_q + 16'h0001 == half_q) begin
                mid_fall_q <= 1'b1;
            end
        end
    end
end
wire clk_fall = dcs_q ? mid_fall_q : enc_fall;

reg [WIDTH-1:0] word_d;
always @* begin
    if (raw_over) begin
        word_d = `APOC_FULL_OB;
    end else if (raw_under) begin
        word_d = `APOC_ZERO_OB;
    end else begin
        word_d = raw_word;
    end
    if (twos_q) begin
        word_d[`APOC_SIGN_BIT] = ~word_d[`APOC_SIGN_BIT];
    end
end

wire ovf_now = raw_over || raw_under;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sample_word <= {WIDTH{1'b0}};
        overflow_flag <= 1'b0;
        output_sample_clock <= 1'b0;
        sample_cnt_q <= 16'h0000;
    end else begin
        if (enc_rise) begin
            output_sample_clock <= 1'b1;
        end else if (clk_fall) begin
            output_sample_clock <= 1'b0;
        end
        if (enc_rise && running) begin
            sample_word <= word_d;
            overflow_flag <= ovf_now;
            sample_cnt_q <= sample_cnt_q + 16'h0001;
        end
    end
end

wire drv = !oe_n && running;
assign sample_word_oe = {WIDTH{drv}};
assign overflow_flag_oe = drv;
assign output_sample_clock_oe = drv;
assign data_valid = running && locked_q;

// ----------------------------------------
// Interrupts
// ----------------------------------------
wire [`APOC_IRQ_W-1:0] irq_set = {lock_evt_q, ready_evt, enc_rise && running && ovf_now};
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_stat_q <= {`APOC_IRQ_W{1'b0}};
    end else if (wr && paddr == `APOC_ADDR_IRQ_STAT) begin
        // Set beats a same-cycle clear
        irq_stat_q <= (irq_stat_q & ~pwdata[`APOC_IRQ_W-1:0]) | irq_set;
    end else begin
        irq_stat_q <= irq_stat_q | irq_set;
    end
end
assign irq = |(irq_stat_q & irq_mask_q);

// Loaded in the setup cycle so the access phase reads a flop
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
        case (paddr)
            `APOC_ADDR_CTRL: prdata <= ctrl_q;
            `APOC_ADDR_STATUS: prdata <= {26'h0, data_valid, locked_q, pst_q[2], pst_q[1], dcs_q, twos_q};
            `APOC_ADDR_IRQ_STAT: prdata <= {29'h0, irq_stat_q};
            `APOC_ADDR_IRQ_MASK: prdata <= {29'h0, irq_mask_q};
            `APOC_ADDR_SAMPLE: prdata <= {19'h0, overflow_flag, sample_word};
            `APOC_ADDR_COUNT: prdata <= {16'h0, sample_cnt_q};
            default: prdata <= 32'h0000_0000;
        endcase
    end else if (!psel) begin
        prdata <= 32'h0000_0000;
    end
end

endmodule // apoc_output_ctrl
`default_nettype wire

// File: testbench/apoc_capture.sv
// Capture model of the far-side logic taking parallel sample words.
// Assumes the sample clock output and its enable come straight from the block.
`default_nettype none
module apoc_capture (
    input wire logic output_sample_clock,
    input wire logic output_sample_clock_oe,
    input wire logic [11:0] sample_word,
    input wire logic overflow_flag,
    output logic [12:0] cap_q
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // Capture register
    // ----------------
    // falling-edge capture
    always @(negedge output_sample_clock) begin
        if (output_sample_clock_oe)
            cap_q <= {overflow_flag, sample_word};
    end
endmodule // apoc_capture
`default_nettype wire

// File: testbench/apoc_output_ctrl_properties.sv
// Checker for the output control block: tri-state, coding and timing relations.
// Assumes the strap stays put between resets.
`default_nettype none
module apoc_props #(
    parameter WIDTH = 12,
    parameter SLEEP_CYCLES = 30000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sampling_edge_pos,
    input wire logic [1:0] mode_strap,
    input wire logic [WIDTH-1:0] raw_word,
    input wire logic raw_over,
    input wire logic raw_under,
    input wire logic [WIDTH-1:0] sample_word,
    input wire logic [WIDTH-1:0] sample_word_oe,
    input wire logic overflow_flag,
    input wire logic overflow_flag_oe,
    input wire logic output_sample_clock,
    input wire logic output_sample_clock_oe,
    input wire logic twos_comp,
    input wire logic stabilizer_on,
    input wire logic sleep_mode,
    input wire logic nap_mode,
    input wire logic data_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    // ---------
    // Relations
    // ---------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_oe_group: assert property (output_sample_clock_oe == overflow_flag_oe &&
        sample_word_oe == {WIDTH{overflow_flag_oe}}) else $error("enables disagree");
    a_oe_hiz: assert property (overflow_flag_oe |-> !sleep_mode && !nap_mode)
        else $error("driving in power-down");
    a_mode_excl: assert property (!(sleep_mode && nap_mode) && !(data_valid && (sleep_mode || nap_mode)))
        else $error("power states overlap");
    a_strap_decode: assert property ($past(presetn, 2) |-> twos_comp == mode_strap[1] &&
        stabilizer_on == ^mode_strap) else $error("strap decode wrong");
    a_strap_static: assert property ($past(presetn, 2) |-> $stable({twos_comp, stabilizer_on}))
        else $error("strap settings moved");
    a_ovf_flag: assert property ($rose(output_sample_clock) && $past(data_valid) |->
        overflow_flag == $past(raw_over || raw_under)) else $error("overflow flag wrong");
    a_word_code: assert property ($rose(output_sample_clock) && $past(data_valid) |->
        sample_word == (($past(raw_over) ? {WIDTH{1'b1}} : $past(raw_under) ? {WIDTH{1'b0}} : $past(raw_word))
        ^ {twos_comp, {(WIDTH-1){1'b0}}})) else $error("sample word wrong");
    a_word_hold: assert property (data_valid && $past(data_valid) && !$rose(output_sample_clock) |->
        $stable({overflow_flag, sample_word})) else $error("word moved off clock rise");
    a_clk_follow: assert property ($rose(sampling_edge_pos) && data_valid |-> ##[1:6] $rose(output_sample_clock))
        else $error("sample clock missed encode rise");
endmodule // apoc_props
bind apoc_output_ctrl apoc_props #(.WIDTH(WIDTH), .SLEEP_CYCLES(SLEEP_CYCLES)) u_apoc_props (
    .pclk, .presetn, .sampling_edge_pos, .mode_strap, .raw_word, .raw_over, .raw_under, .sample_word,
    .sample_word_oe, .overflow_flag, .overflow_flag_oe, .output_sample_clock, .output_sample_clock_oe,
    .twos_comp, .stabilizer_on, .sleep_mode, .nap_mode, .data_valid
);
`default_nettype wire

// File: testbench/tb_top.sv
// Bench for the output control block: APB master, encode clock, scenarios.
// Assumes the capture model and the bound checker are compiled first.
`default_nettype none
`include "apoc_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [13:0] TBL [3] = '{14'h0123, 14'h2456, 14'h1789};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, enc = 0, rov = 0, rund = 0, perr;
    logic [11:0] paddr = 0, raw = 0;
    logic [31:0] pwdata = 0, rd;
    logic [1:0] strap = 0;
    wire logic [31:0] prdata;
    wire logic [11:0] sw, swoe;
    wire logic [12:0] cap;
    wire logic pready, pslverr, ofl, ofoe, osc, osce, tc, st, slp, nap, dv, irq;
    int err_count = 0;
    int n_compared = 0;
    int n;
    // --------------------
    // Block, partner, clocks
    // --------------------
    apoc_output_ctrl #(.SLEEP_CYCLES(50)) u_apoc_output_ctrl (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .sampling_edge_pos(enc), .mode_strap(strap), .raw_word(raw), .raw_over(rov), .raw_under(rund),
        .sample_word(sw), .sample_word_oe(swoe), .overflow_flag(ofl), .overflow_flag_oe(ofoe),
        .output_sample_clock(osc), .output_sample_clock_oe(osce), .twos_comp(tc), .stabilizer_on(st),
        .sleep_mode(slp), .nap_mode(nap), .data_valid(dv), .irq
    );
    apoc_capture u_apoc_capture (.output_sample_clock(osc), .output_sample_clock_oe(osce),
        .sample_word(sw), .overflow_flag(ofl), .cap_q(cap));
    initial forever #50 pclk = ~pclk;
    // Odd offset keeps encode edges off the pclk edges
    initial begin
        #137;
        forever #400 enc = ~enc;
    end
    // -----
    // Tasks
    // -----
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rst(input logic [1:0] s);
        @(posedge pclk);
        presetn <= 0;
        strap <= s;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
    endtask
    task results;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task t_strap;
        for (int s = 0; s < 4; s++) begin
            rst(s[1:0]);
            chk(tc, s > 1, "coding select");
            chk(st, s == 1 || s == 2, "stabilizer select");
        end
    endtask
    task t_regs;
        apb(0, `APOC_ADDR_CTRL, 0);
        chk(rd, `APOC_CTRL_RESET, "ctrl reset value");
        chk(swoe, 0, "outputs off at reset");
        apb(0, `APOC_ADDR_STATUS, 0);
        chk(rd[1:0], 2'b01, "status strap bits");
        apb(0, 12'h0F0, 0);
        chk(perr, 1, "unmapped error");
        chk(rd, 0, "unmapped data");
    endtask
    task t_stream(input logic [1:0] s);
        logic [13:0] v;
        logic [12:0] e;
        rst(s);
        apb(1, `APOC_ADDR_CTRL, 0);
        apb(1, `APOC_ADDR_IRQ_MASK, 1);
        while (dv !== 1'b1) @(posedge pclk);
        apb(0, `APOC_ADDR_IRQ_STAT, 0);
        chk(rd[2], s == 2'd2, "relock event");
        for (int i = 0; i < 3; i++) begin
            v = TBL[i];
            {rov, rund, raw} <= v;
            repeat (3) @(negedge osc);
            @(posedge pclk);
            e = {|v[13:12], (v[13] ? 12'hFFF : v[12] ? 12'h000 : v[11:0]) ^ {s[1], 11'h000}};
            chk(cap, e, "captured word");
            chk(irq, i > 0, "overflow irq");
        end
        {rov, rund} <= 0;
        repeat (3) @(negedge osc);
        apb(0, `APOC_ADDR_SAMPLE, 0);
        chk(rd, {20'h0, TBL[2][11:0] ^ {s[1], 11'h000}}, "sample register");
        apb(1, `APOC_ADDR_IRQ_STAT, 1);
        @(posedge pclk);
        chk(irq, 0, "irq cleared");
    endtask
    // Enable changes only around long idle spans
    task t_power;
        apb(1, `APOC_ADDR_CTRL, 1);
        @(posedge pclk);
        chk({osce, ofoe, swoe}, 0, "outputs off");
        apb(1, `APOC_ADDR_CTRL, 2);
        repeat (4) @(posedge pclk);
        chk({nap, slp, osce, ofoe, swoe}, 16'h8000, "nap state");
        apb(1, `APOC_ADDR_CTRL, 0);
        n = 0;
        while (dv !== 1'b1 && n < 300) begin
            @(posedge enc);
            n++;
        end
        chk(n >= 99 && n <= 102, 1, "nap recovery");
        apb(1, `APOC_ADDR_CTRL, 3);
        repeat (4) @(posedge pclk);
        chk({slp, nap, osce}, 3'b100, "sleep state");
        apb(1, `APOC_ADDR_CTRL, 1);
        n = 0;
        while (dv !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk(n >= 48 && n <= 56, 1, "sleep recovery");
        apb(0, `APOC_ADDR_IRQ_STAT, 0);
        chk(rd[1], 1, "recovery event");
    endtask
    // ---------
    // Sequence
    // ---------
    initial begin
        t_strap();
        t_regs();
        t_stream(2'd2);
        t_stream(2'd0);
        t_power();
        results();
    end
    initial begin
        repeat (30000) @(posedge pclk);
        err_count++;
        results();
    end
endmodule // tb_top
`default_nettype wire
